/* File: logic/vsrc_pkg.sv */
// Purpose: shared constants for the volume step repeat controller
// Assumes: one clock mclk at 20 MHz
// Notes: volume is an index into a gain table held elsewhere
package vsrc_pkg;
    // ----------------------------------------------------------------
    // volume index
    // ----------------------------------------------------------------
    localparam int VOL_W = 5;
    localparam logic [4:0] VOL_MAX = 5'h1f;
    localparam logic [4:0] VOL_MIN = 5'h00;
    // default indices, arbitrary table positions for -10dB and -16dB
    localparam logic [4:0] VOL_DEF_BRIDGED = 5'h1a;
    localparam logic [4:0] VOL_DEF_SINGLE = 5'h17;
    // ----------------------------------------------------------------
    // step timing in internal clock pulses
    // ----------------------------------------------------------------
    localparam int CLK_DIV = 2;
    localparam int EXT_CLK_MAX_KHZ = 100;
    localparam logic [5:0] STEP_FIRST = 6'h04;
    localparam logic [5:0] STEP_SECOND = 6'h28;
    localparam logic [5:0] STEP_THIRD = 6'h14;
    localparam logic [5:0] STEP_FOURTH = 6'h0c;
    localparam logic [5:0] STEP_FIFTH = 6'h08;
    localparam logic [5:0] STEP_REPEAT = 6'h04;
    // ----------------------------------------------------------------
    // repeat stage
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        VSRC_IDLE = 3'h0,
        VSRC_S1 = 3'h1,
        VSRC_S2 = 3'h3,
        VSRC_S3 = 3'h2,
        VSRC_S4 = 3'h6,
        VSRC_S5 = 3'h7,
        VSRC_REP = 3'h5
    } vsrc_stage_t;
endpackage : vsrc_pkg

/* File: logic/vsrc_tick_if.sv */
// Purpose: carries the internal clock pulse between modules
// Assumes: single clock domain
// Notes: tick is a one-cycle enable
interface vsrc_tick_if;
    logic tick;
    modport src (output tick);
    modport dst (input tick);
endinterface : vsrc_tick_if

/* File: logic/vsrc_clk_div.sv */
// Purpose: makes the internal clock pulse from an external clock pin
// Assumes: extClk synchronous to mclk and far slower than it
// Notes: one pulse per CLK_DIV rising edges of extClk
module vsrc_clk_div
    import vsrc_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic extClk,
    vsrc_tick_if.src tickOut
);
    logic extClk_reg;
    logic divCnt_reg;
    logic extRise;

    // rising edge of the external clock
    assign extRise = extClk && !extClk_reg;

    // edge detector history
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            extClk_reg <= 1'b0;
        else
            extClk_reg <= extClk;
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            divCnt_reg <= 1'b0;
        else if (extRise)
            divCnt_reg <= !divCnt_reg;
    end

    assign tickOut.tick = extRise && divCnt_reg;

    a_div_half: assert property (@(posedge mclk) disable iff (!resetn)
        extRise |=> divCnt_reg != $past(divCnt_reg))
        else $error("divider missed an external edge");
endmodule : vsrc_clk_div

/* File: logic/vsrc_volume_ctrl.sv */
// Purpose: step up and down volume control with accelerating repeat
// Assumes: step inputs synchronous to mclk; external controller keeps clock slow
// Notes: power supply status arrives as plain level inputs
// What this block does
// - internal clock is external clock halved
// - one input held 4 pulses steps once
// - repeats after 40, 20, 12, 8, then 4
// - release restarts the interval sequence
// - both inputs high gives no change
// - volume kept while backup supply present
// - default volume only after full power loss
module vsrc_volume_ctrl
    import vsrc_pkg::*;
#(
    parameter int VOLW = VOL_W
)
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic extClk,
    input wire logic stepUp,
    input wire logic stepDown,
    input wire logic mainPowerOk,
    input wire logic backup_supply,
    input wire logic bridgedMode,
    output logic [VOLW-1:0] volume,
    output logic stepPulse
);
    // ----------------------------------------------------------------
    // internal clock
    // ----------------------------------------------------------------
    vsrc_tick_if tickBus ();
    vsrc_clk_div uDiv (
        .mclk(mclk),
        .resetn(resetn),
        .extClk(extClk),
        .tickOut(tickBus)
    );

    // ----------------------------------------------------------------
    // step timing
    // ----------------------------------------------------------------
    vsrc_stage_t stage_reg;
    vsrc_stage_t stage_next;
    logic [5:0] pulseCnt_reg;
    logic [5:0] target;
    logic oneHeld;
    logic dirUp_reg;
    logic stepNow;
    logic lost_reg;
    logic [VOLW-1:0] vol_reg;

    assign oneHeld = stepUp ^ stepDown;

    // interval for the current stage
    always_comb
    begin
        case (stage_reg)
            VSRC_S1: target = STEP_FIRST;
            VSRC_S2: target = STEP_SECOND;
            VSRC_S3: target = STEP_THIRD;
            VSRC_S4: target = STEP_FOURTH;
            VSRC_S5: target = STEP_FIFTH;
            default: target = STEP_REPEAT;
        endcase
    end

    // a flip of direction in one cycle must not step the new way
    assign stepNow = (stage_reg != VSRC_IDLE) && oneHeld && tickBus.tick
        && (dirUp_reg == stepUp) && (pulseCnt_reg + 6'h01 == target);

    always_comb
    begin
        case (stage_reg)
            VSRC_S1: stage_next = VSRC_S2;
            VSRC_S2: stage_next = VSRC_S3;
            VSRC_S3: stage_next = VSRC_S4;
            VSRC_S4: stage_next = VSRC_S5;
            VSRC_S5: stage_next = VSRC_REP;
            default: stage_next = VSRC_REP;
        endcase
    end

    // restart on release or direction change
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            stage_reg <= VSRC_IDLE;
        else if (!oneHeld || (stage_reg != VSRC_IDLE && dirUp_reg != stepUp))
            stage_reg <= VSRC_IDLE;
        else if (stage_reg == VSRC_IDLE)
            stage_reg <= VSRC_S1;
        else if (stepNow)
            stage_reg <= stage_next;
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            pulseCnt_reg <= 6'h00;
        else if (!oneHeld || stage_reg == VSRC_IDLE || stepNow)
            pulseCnt_reg <= 6'h00;
        else if (tickBus.tick)
            pulseCnt_reg <= pulseCnt_reg + 6'h01;
    end

    // direction latched at press start
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            dirUp_reg <= 1'b0;
        else if (stage_reg == VSRC_IDLE)
            dirUp_reg <= stepUp;
    end

    // ----------------------------------------------------------------
    // retained volume
    // ----------------------------------------------------------------
    // marks loss of both supplies
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            lost_reg <= 1'b1;
        else if (!mainPowerOk && !backup_supply)
            lost_reg <= 1'b1;
        else if (mainPowerOk)
            lost_reg <= 1'b0;
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            vol_reg <= VOL_DEF_BRIDGED;
        else if (mainPowerOk && lost_reg)
            vol_reg <= bridgedMode ? VOL_DEF_BRIDGED : VOL_DEF_SINGLE;
        else if (mainPowerOk && stepNow && stepUp && vol_reg != VOL_MAX)
            vol_reg <= vol_reg + 5'h01;
        else if (mainPowerOk && stepNow && stepDown && vol_reg != VOL_MIN)
            vol_reg <= vol_reg - 5'h01;
    end

    assign volume = vol_reg;
    assign stepPulse = stepNow && mainPowerOk && !lost_reg;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    // check helper: ticks since the last step of this press
    logic [5:0] tickGap_reg;
    // check helper: steps taken in this press, stops at five
    logic [2:0] stepCount_reg;

    // tick count kept apart from the stage machine
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            tickGap_reg <= 6'h00;
        else if (stage_reg == VSRC_IDLE || stepNow)
            tickGap_reg <= 6'h00;
        else if (tickBus.tick)
            tickGap_reg <= tickGap_reg + 6'h01;
    end

    // step index within the press
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            stepCount_reg <= 3'h0;
        else if (stage_reg == VSRC_IDLE)
            stepCount_reg <= 3'h0;
        else if (stepNow && stepCount_reg != 3'h5)
            stepCount_reg <= stepCount_reg + 3'h1;
    end

    a_both_hold: assert property (@(posedge mclk) disable iff (!resetn)
        stepUp && stepDown && !lost_reg |=> $stable(vol_reg))
        else $error("volume moved with both inputs high");
    a_top_sat: assert property (@(posedge mclk) disable iff (!resetn)
        vol_reg == VOL_MAX && stepUp && !stepDown && !lost_reg |=> vol_reg == VOL_MAX)
        else $error("volume wrapped");
    a_release_idle: assert property (@(posedge mclk) disable iff (!resetn)
        !oneHeld |=> stage_reg == VSRC_IDLE)
        else $error("stage kept after release");
    a_backup_keep: assert property (@(posedge mclk) disable iff (!resetn)
        !mainPowerOk |=> $stable(vol_reg))
        else $error("volume changed without main power");
    a_default_vol: assert property (@(posedge mclk) disable iff (!resetn)
        mainPowerOk && lost_reg && bridgedMode |=> vol_reg == VOL_DEF_BRIDGED)
        else $error("bridged default not applied");
    a_first_step: assert property (@(posedge mclk) disable iff (!resetn)
        stepNow && stepCount_reg == 3'h0 |-> tickGap_reg == STEP_FIRST - 6'h01)
        else $error("first step timing wrong");
    a_second_gap: assert property (@(posedge mclk) disable iff (!resetn)
        stepNow && stepCount_reg == 3'h1 |-> tickGap_reg == STEP_SECOND - 6'h01)
        else $error("second interval wrong");
    a_third_gap: assert property (@(posedge mclk) disable iff (!resetn)
        stepNow && stepCount_reg == 3'h2 |-> tickGap_reg == STEP_THIRD - 6'h01)
        else $error("third interval wrong");
    a_fourth_gap: assert property (@(posedge mclk) disable iff (!resetn)
        stepNow && stepCount_reg == 3'h3 |-> tickGap_reg == STEP_FOURTH - 6'h01)
        else $error("fourth interval wrong");
    a_fifth_gap: assert property (@(posedge mclk) disable iff (!resetn)
        stepNow && stepCount_reg == 3'h4 |-> tickGap_reg == STEP_FIFTH - 6'h01)
        else $error("fifth interval wrong");
    a_repeat_gap: assert property (@(posedge mclk) disable iff (!resetn)
        stepNow && stepCount_reg == 3'h5 |-> tickGap_reg == STEP_REPEAT - 6'h01)
        else $error("repeat interval wrong");

    // both supplies gone, then main back in single-ended mode
    sequence s_full_loss;
        !mainPowerOk && !backup_supply;
    endsequence
    sequence s_main_single;
        mainPowerOk && !bridgedMode;
    endsequence
    a_single_def: assert property (@(posedge mclk) disable iff (!resetn)
        s_full_loss ##1 s_main_single |=> vol_reg == VOL_DEF_SINGLE)
        else $error("single-ended default not applied");
endmodule : vsrc_volume_ctrl

/* File: sim/vsrc_ctrl_model.sv */
// Purpose: external controller driving the clock pin of the volume controller
// Assumes: free-running clock pin, slower than 100 kHz
// Notes: counts rising edges so the bench can time steps
module vsrc_ctrl_model
#(
    parameter int HALF_CYC = 102
)
(
    input logic mclk,
    output logic extClk,
    output int extEdges
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------------------------------
    // clock pin
    // ----------------------------------------------------------------
    // half period of 102 mclk cycles, 10.2 us period
    // pin moves on the mclk rising edge, as a synchronous input must
    initial
    begin
        extClk = 1'b0;
        extEdges = 0;
        forever
        begin
            repeat (HALF_CYC) @(posedge mclk);
            extClk <= ~extClk;
            if (!extClk)
                extEdges <= extEdges + 1;
        end
    end
endmodule : vsrc_ctrl_model

/* File: sim/tb_vsrc_volume_ctrl.sv */
// Purpose: self-checking bench for the volume step repeat controller
// Assumes: mclk 20 MHz, external clock from the controller model
// Notes: step gaps are timed in external clock edges
module tb_vsrc_volume_ctrl;
    timeunit 1ns;
    timeprecision 1ns;
    import vsrc_pkg::*;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic stepUp = 1'b0;
    logic stepDown = 1'b0;
    logic mainPowerOk = 1'b1;
    logic backup_supply = 1'b1;
    logic bridgedMode = 1'b1;
    logic extClk;
    int extEdges;
    logic [4:0] volume;
    logic stepPulse;
    int n_mismatch = 0;
    int total_checks = 0;
    int seed = 32'h0c9ee23d;
    int r;
    bit got;
    // ----------------------------------------------------------------
    // clock, parts under test
    // ----------------------------------------------------------------
    initial
    begin
        forever #25 mclk = ~mclk;
    end
    vsrc_ctrl_model #(.HALF_CYC(102)) i_vsrc_ctrl_model (.mclk(mclk), .extClk(extClk),
        .extEdges(extEdges));
    vsrc_volume_ctrl i_vsrc_volume_ctrl (.mclk(mclk), .resetn(resetn), .extClk(extClk),
        .stepUp(stepUp), .stepDown(stepDown), .mainPowerOk(mainPowerOk),
        .backup_supply(backup_supply), .bridgedMode(bridgedMode), .volume(volume),
        .stepPulse(stepPulse));
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    task results;
        if (n_mismatch == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : results
    // ticks expected before step k of a held press
    function automatic int gap(input int k);
        case (k)
            0: return STEP_FIRST;
            1: return STEP_SECOND;
            2: return STEP_THIRD;
            3: return STEP_FOURTH;
            4: return STEP_FIFTH;
            default: return STEP_REPEAT;
        endcase
    endfunction : gap
    task wait_step(input int lim, output bit hit);
        hit = 0;
        for (int i = 0; i < lim && !hit; i++)
        begin
            @(negedge mclk);
            hit = (stepPulse === 1'b1);
        end
    endtask : wait_step
    // holds one input for n steps, timing each gap
    task press(input logic up, input int n, input logic [4:0] v0);
        int s;
        int e;
        logic [4:0] v;
        v = v0;
        @(posedge mclk);
        stepUp <= up;
        stepDown <= ~up;
        // edge count taken once the press edge has settled
        @(negedge mclk);
        for (int k = 0; k < n; k++)
        begin
            s = extEdges;
            wait_step(gap(k) * 408 + 500, got);
            check("step seen", got, 1'b1);
            e = extEdges - s;
            if (k == 0)
                e = 2 * ((e + 1) / 2);
            check("step gap", e, 2 * gap(k));
            v = up ? (v == VOL_MAX ? v : v + 5'h01) : (v == VOL_MIN ? v : v - 5'h01);
            @(negedge mclk);
            check("volume", volume, v);
        end
    endtask : press
    // ----------------------------------------------------------------
    // main sequence and watchdog
    // ----------------------------------------------------------------
    initial
    begin
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        repeat (3) @(negedge mclk);
        check("default", volume, VOL_DEF_BRIDGED);
        r = 1 + ($unsigned($random(seed)) % 3);
        @(posedge mclk);
        stepUp <= 1'b1;
        wait_step(r * 408, got);
        check("short press", got, 1'b0);
        // one-cycle release, the next press must start over at four
        @(posedge mclk);
        stepUp <= 1'b0;
        press(1'b1, 5, VOL_DEF_BRIDGED);
        repeat (5000) @(negedge mclk);
        check("top held", volume, VOL_MAX);
        @(posedge mclk);
        stepDown <= 1'b1;
        stepUp <= 1'b1;
        wait_step(4080, got);
        check("both high", got, 1'b0);
        press(1'b0, 6, VOL_MAX);
        @(posedge mclk);
        mainPowerOk <= 1'b0;
        repeat (4000) @(posedge mclk);
        mainPowerOk <= 1'b1;
        stepDown <= 1'b0;
        repeat (4) @(negedge mclk);
        check("kept", volume, VOL_MAX - 5'h06);
        @(posedge mclk);
        mainPowerOk <= 1'b0;
        backup_supply <= 1'b0;
        bridgedMode <= 1'b0;
        repeat (10) @(posedge mclk);
        mainPowerOk <= 1'b1;
        backup_supply <= 1'b1;
        repeat (4) @(negedge mclk);
        check("default", volume, VOL_DEF_SINGLE);
        results;
    end
    initial
    begin
        #4600000;
        n_mismatch++;
        results;
    end
endmodule : tb_vsrc_volume_ctrl
